// ---- rtl/fba_block_access.sv ----
// Block window, checksum commit and key-based security levels.
// Assumes a bus front end that gives one byte access per strobe and marks
// the first byte of each write transaction.
`timescale 1ns/1ps
module fba_block_access (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic i_wr_start,
    input wire logic i_wr_en,
    input wire logic [7:0] i_wr_data,
    input wire logic i_rd_en,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    output logic [15:0] o_control_status,
    output logic o_commit
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [255:0] win_reg;
    logic win_valid_reg;
    logic [7:0] class_reg;
    logic [7:0] block_reg;
    logic [7:0] access_ctrl_reg;
    logic [7:0] ctrl_lo_reg;
    logic ovf_reg;
    logic [5:0] len_cnt_reg;
    logic load_req_reg;
    fba_pkg::fba_sec_type sec_reg, sec_next;
    fba_pkg::fba_keyseq_type keyseq_reg, keyseq_next;
    logic [255:0] nv_block;
    logic [63:0] key_words;
    logic sealed;
    logic general;
    logic [6:0] gen_row;
    logic [6:0] row_sel;
    logic sel_ok;
    logic win_writable;
    logic [7:0] win_sum;
    logic [5:0] len_eff;
    logic win_hit;
    logic win_accept;
    logic commit;
    logic ctrl_word_wr;
    logic [15:0] ctrl_word;
    logic [7:0] rd_next;

    // ------------------------------------------------------------------
    // Block selection
    // ------------------------------------------------------------------
    assign sealed = (sec_reg == fba_pkg::SEC_SEALED);
    assign general = (access_ctrl_reg == fba_pkg::GENERAL_ACCESS)
        && !sealed; // R1 R11
    // Info blocks alias the first rows of their subclass in both modes
    always_comb
    begin
        if (class_reg == fba_pkg::MFR_SUBCLASS && block_reg < 8'h03)
        begin
            gen_row = block_reg[6:0]; // R10
        end
        else
        begin
            gen_row = 7'(fba_pkg::NV_GEN_BASE
                + {class_reg[3:0], block_reg[1:0]}); // R5
        end
    end
    always_comb
    begin
        if (general)
        begin
            row_sel = gen_row;
            sel_ok = 1'b1;
        end
        else
        begin
            row_sel = 7'(block_reg[6:0] - 7'h01); // R11
            sel_ok = (block_reg >= fba_pkg::INFO_A)
                && (block_reg <= fba_pkg::INFO_C); // R9 R11
        end
    end
    // Sealed reads public info blocks only; block A cannot be edited
    assign win_writable = win_valid_reg
        && !(sealed && block_reg == fba_pkg::INFO_A); // R12 R13

    // ------------------------------------------------------------------
    // Window writes and transaction length
    // ------------------------------------------------------------------
    assign win_hit = i_wr_en && i_addr >= fba_pkg::CMD_WIN_BASE
        && i_addr <= fba_pkg::CMD_WIN_LAST;
    assign len_eff = i_wr_start ? 6'h00 : len_cnt_reg;
    assign win_accept = win_hit && win_writable
        && len_eff < fba_pkg::BLOCK_BYTES_W; // R7

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            len_cnt_reg <= 6'h00;
        end
        else if (i_wr_start)
        begin
            len_cnt_reg <= win_hit ? 6'h01 : 6'h00;
        end
        else if (win_hit && len_cnt_reg != fba_pkg::LEN_MAX)
        begin
            len_cnt_reg <= 6'(len_cnt_reg + 6'h01);
        end
    end

    // An overlong write poisons the window until the next block load
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ovf_reg <= 1'b0;
        end
        else if (win_hit && len_eff >= fba_pkg::BLOCK_BYTES_W)
        begin
            ovf_reg <= 1'b1; // R7
        end
        else if (load_req_reg)
        begin
            ovf_reg <= 1'b0;
        end
    end

    // Values are stored as written, with no bound checks
    genvar gi;
    generate
        for (gi = 0; gi < fba_pkg::BLOCK_BYTES; gi++)
        begin : g_win
            always_ff @(posedge i_core_clk or posedge i_rst)
            begin
                if (i_rst)
                begin
                    win_reg[8*gi +: 8] <= 8'h00;
                end
                else if (load_req_reg)
                begin
                    win_reg[8*gi +: 8] <= sel_ok ? nv_block[8*gi +: 8]
                        : 8'h00; // R2
                end
                else if (win_accept && i_addr[4:0] == 5'(gi))
                begin
                    win_reg[8*gi +: 8] <= i_wr_data; // R3 R8
                end
            end
        end
    endgenerate

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            win_valid_reg <= 1'b0;
        end
        else if (load_req_reg)
        begin
            win_valid_reg <= sel_ok;
        end
    end

    // ------------------------------------------------------------------
    // Selection registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            class_reg <= fba_pkg::SELECT_RESET;
            block_reg <= fba_pkg::SELECT_RESET;
            access_ctrl_reg <= fba_pkg::ACCESS_CTRL_RESET;
            load_req_reg <= 1'b0;
        end
        else
        begin
            load_req_reg <= 1'b0;
            if (i_wr_en && i_addr == fba_pkg::CMD_CLASS && !sealed)
            begin
                class_reg <= i_wr_data; // R22
                load_req_reg <= 1'b1;
            end
            if (i_wr_en && i_addr == fba_pkg::CMD_BLOCK)
            begin
                block_reg <= i_wr_data; // R5 R11
                load_req_reg <= 1'b1;
            end
            if (i_wr_en && i_addr == fba_pkg::CMD_ACCESS_CTRL && !sealed)
            begin
                access_ctrl_reg <= i_wr_data; // R1
                load_req_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checksum commit
    // ------------------------------------------------------------------
    always_comb
    begin
        win_sum = 8'h00;
        for (int i = 0; i < fba_pkg::BLOCK_BYTES; i++)
        begin
            win_sum = 8'(win_sum + win_reg[8*i +: 8]);
        end
    end
    // Key row writes need full access so keys cannot be replaced lower
    assign commit = i_wr_en && i_addr == fba_pkg::CMD_CHECKSUM
        && win_writable && !ovf_reg && !load_req_reg
        && i_wr_data == ~win_sum
        && !(general && gen_row == fba_pkg::NV_KEY_ROW
        && sec_reg != fba_pkg::SEC_FULL); // R4 R14 R23

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_commit <= 1'b0;
        end
        else
        begin
            o_commit <= commit;
        end
    end

    fba_nv_store u_nv (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_rd_row(row_sel),
        .o_rd_block(nv_block),
        .i_wr_en(commit),
        .i_wr_row(row_sel),
        .i_wr_block(win_reg),
        .o_key_words(key_words)
    );

    // ------------------------------------------------------------------
    // Key sequence and security level
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl_lo_reg <= 8'h00;
        end
        else if (i_wr_en && i_addr == fba_pkg::CMD_CTRL_LO)
        begin
            ctrl_lo_reg <= i_wr_data;
        end
    end
    assign ctrl_word_wr = i_wr_en && i_addr == fba_pkg::CMD_CTRL_HI;
    assign ctrl_word = {i_wr_data, ctrl_lo_reg};

    // Keys arrive byte-swapped relative to their stored order, which the
    // little-endian packing of the key row already accounts for
    always_comb
    begin
        sec_next = sec_reg;
        keyseq_next = keyseq_reg;
        if (ctrl_word_wr)
        begin
            keyseq_next = fba_pkg::KS_IDLE; // R15
            unique case (keyseq_reg)
                fba_pkg::KS_IDLE:
                begin
                    if (sealed && ctrl_word == key_words[15:0])
                    begin
                        keyseq_next = fba_pkg::KS_UNSEAL; // R20
                    end
                    else if (sec_reg == fba_pkg::SEC_UNSEALED
                        && ctrl_word == key_words[47:32])
                    begin
                        keyseq_next = fba_pkg::KS_FULL; // R24
                    end
                    else if (!sealed && ctrl_word == fba_pkg::CTRL_SEAL_CMD)
                    begin
                        sec_next = fba_pkg::SEC_SEALED;
                    end
                end
                fba_pkg::KS_UNSEAL:
                begin
                    if (ctrl_word == key_words[31:16])
                    begin
                        sec_next = fba_pkg::SEC_UNSEALED; // R17
                    end
                end
                fba_pkg::KS_FULL:
                begin
                    if (ctrl_word == key_words[63:48])
                    begin
                        sec_next = fba_pkg::SEC_FULL; // R18
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sec_reg <= fba_pkg::SEC_SEALED;
            keyseq_reg <= fba_pkg::KS_IDLE;
            o_control_status <= fba_pkg::STATUS_RESET;
        end
        else
        begin
            sec_reg <= sec_next;
            keyseq_reg <= keyseq_next;
            o_control_status <= 16'h0000;
            o_control_status[fba_pkg::STAT_SEALED_BIT] <=
                (sec_next == fba_pkg::SEC_SEALED); // R17
            o_control_status[fba_pkg::STAT_FULL_BIT] <=
                (sec_next != fba_pkg::SEC_FULL); // R18
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_comb
    begin
        rd_next = 8'h00;
        if (i_addr >= fba_pkg::CMD_WIN_BASE
            && i_addr <= fba_pkg::CMD_WIN_LAST)
        begin
            rd_next = win_valid_reg ? win_reg[8*i_addr[4:0] +: 8] : 8'h00;
        end
        else if (i_addr == fba_pkg::CMD_CTRL_LO)
        begin
            rd_next = o_control_status[7:0];
        end
        else if (i_addr == fba_pkg::CMD_CTRL_HI)
        begin
            rd_next = o_control_status[15:8];
        end
        else if (i_addr == fba_pkg::CMD_CLASS && !sealed)
        begin
            rd_next = class_reg;
        end
        else if (i_addr == fba_pkg::CMD_BLOCK)
        begin
            rd_next = block_reg;
        end
        else if (i_addr == fba_pkg::CMD_CHECKSUM)
        begin
            rd_next = ~win_sum;
        end
        else if (i_addr == fba_pkg::CMD_ACCESS_CTRL && !sealed)
        begin
            rd_next = access_ctrl_reg;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_rd_data <= 8'h00;
            o_rd_valid <= 1'b0;
        end
        else
        begin
            o_rd_valid <= i_rd_en;
            if (i_rd_en)
            begin
                o_rd_data <= rd_next;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_commit_needs_sum: assert property ( // R4
        @(posedge i_core_clk) disable iff (i_rst)
        o_commit |-> $past(i_addr) == fba_pkg::CMD_CHECKSUM
            && $past(i_wr_data) == ~$past(win_sum))
        else $error("commit without matching checksum");
    a_bad_sum_idle: assert property ( // R23
        @(posedge i_core_clk) disable iff (i_rst)
        (i_wr_en && i_addr == fba_pkg::CMD_CHECKSUM
            && i_wr_data != ~win_sum && !load_req_reg)
        |=> !o_commit && win_reg == $past(win_reg))
        else $error("bad checksum changed state");
    a_overflow_blocks: assert property ( // R7
        @(posedge i_core_clk) disable iff (i_rst)
        (ovf_reg && !load_req_reg && i_wr_en
            && i_addr == fba_pkg::CMD_CHECKSUM)
        |=> !o_commit)
        else $error("commit after overlong write");
    a_excess_dropped: assert property ( // R7
        @(posedge i_core_clk) disable iff (i_rst)
        (win_hit && len_eff >= fba_pkg::BLOCK_BYTES_W && !load_req_reg)
        |=> win_reg == $past(win_reg))
        else $error("byte past block end was stored");
    a_info_a_ro: assert property ( // R12
        @(posedge i_core_clk) disable iff (i_rst)
        (sealed && block_reg == fba_pkg::INFO_A && !load_req_reg)
        |=> win_reg == $past(win_reg))
        else $error("sealed block A was modified");
    a_unseal_pair: assert property ( // R17
        @(posedge i_core_clk) disable iff (i_rst)
        $fell(o_control_status[fba_pkg::STAT_SEALED_BIT])
        |-> $past(keyseq_reg == fba_pkg::KS_UNSEAL && ctrl_word_wr
            && ctrl_word == key_words[31:16]))
        else $error("sealed flag cleared without key pair");
    a_full_pair: assert property ( // R18
        @(posedge i_core_clk) disable iff (i_rst)
        $fell(o_control_status[fba_pkg::STAT_FULL_BIT])
        |-> $past(keyseq_reg == fba_pkg::KS_FULL && ctrl_word_wr
            && ctrl_word == key_words[63:48]))
        else $error("full access flag cleared without key pair");
    a_seq_cancel: assert property ( // R15
        @(posedge i_core_clk) disable iff (i_rst)
        (keyseq_reg != fba_pkg::KS_IDLE && ctrl_word_wr)
        |=> keyseq_reg == fba_pkg::KS_IDLE)
        else $error("key sequence not ended by control write");
    a_sealed_class: assert property ( // R22
        @(posedge i_core_clk) disable iff (i_rst)
        (sealed && i_wr_en && i_addr == fba_pkg::CMD_CLASS)
        |=> class_reg == $past(class_reg) && !general)
        else $error("class select accepted while sealed");
    a_key_full_only: assert property ( // R14
        @(posedge i_core_clk) disable iff (i_rst)
        o_commit && $past(general && gen_row == fba_pkg::NV_KEY_ROW)
        |-> $past(sec_reg) == fba_pkg::SEC_FULL)
        else $error("keys written below full access");
    a_level_hold: assert property ( // R24
        @(posedge i_core_clk) disable iff (i_rst)
        (keyseq_reg == fba_pkg::KS_IDLE && ctrl_word_wr
            && ctrl_word != fba_pkg::CTRL_SEAL_CMD)
        |=> sec_reg == $past(sec_reg))
        else $error("level changed on first key word");
endmodule // fba_block_access

// ---- rtl/fba_nv_store.sv ----
// Parameter memory rows of one block each, plus the transition keys.
// Assumes whole-row writes from the access path, one row per cycle.
`timescale 1ns/1ps
module fba_nv_store (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [6:0] i_rd_row,
    output logic [255:0] o_rd_block,
    input wire logic i_wr_en,
    input wire logic [6:0] i_wr_row,
    input wire logic [255:0] i_wr_block,
    output logic [63:0] o_key_words
);
    // Array contents survive reset, as parameter memory must
    logic [255:0] mem [fba_pkg::NV_ROWS];
    logic [63:0] key_reg;

    always_ff @(posedge i_core_clk)
    begin
        if (i_wr_en)
        begin
            mem[i_wr_row] <= i_wr_block;
        end
    end

    // Keys kept in flops too so they hold a defined value from reset
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            key_reg <= fba_pkg::KEY_RESET;
        end
        else if (i_wr_en && i_wr_row == fba_pkg::NV_KEY_ROW)
        begin
            key_reg <= i_wr_block[63:0]; // R19
        end
    end

    always_comb
    begin
        o_rd_block = mem[i_rd_row];
        if (i_rd_row == fba_pkg::NV_KEY_ROW)
        begin
            o_rd_block[63:0] = key_reg;
        end
    end

    assign o_key_words = key_reg;
endmodule // fba_nv_store

// ---- rtl/fba_pkg.sv ----
// Constants, encodings and types for the block access and security path.
// Assumes a byte-wide command space driven by a serial bus front end.
// Overview of operation
// [R1] Access control zero maps general parameter blocks
// [R2] Window exposes 32 selected block bytes
// [R3] Single window bytes readable and writable
// [R4] Commit window only on correct checksum write
// [R5] Block select picks 32-byte block
// [R6] Host sets class then block first
// [R7] Overlong block writes are discarded
// [R8] Written parameter values are never range checked
// [R9] Three info blocks, 96 bytes stored
// [R10] Unsealed general mode treats info blocks normally
// [R11] Info mode selects blocks A, B, C
// [R12] Sealed mode makes info block A read-only
// [R13] Sealed reads public only, unsealed writes; code lets sealed commit info blocks B and C
// [R14] Keys update only in full access
// [R15] Two consecutive key words; other write cancels
// [R16] Keys must differ from subcommand codes
// [R17] Sealed flag clears on correct unseal pair
// [R18] Full access flag clears on full pair
// [R19] Keys stored in parameter memory as words
// [R20] Host byte-swaps each key word
// [R21] Host checksum is complemented byte sum
// [R22] Sealed denies class and block general access
// [R23] Bad checksum changes nothing
// [R24] Redundant or wrong keys change nothing
package fba_pkg;
    // ------------------------------------------------------------------
    // Command space
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_CTRL_LO = 8'h00;
    localparam logic [7:0] CMD_CTRL_HI = 8'h01;
    localparam logic [7:0] CMD_CLASS = 8'h3e;
    localparam logic [7:0] CMD_BLOCK = 8'h3f;
    localparam logic [7:0] CMD_WIN_BASE = 8'h40;
    localparam logic [7:0] CMD_WIN_LAST = 8'h5f;
    localparam logic [7:0] CMD_CHECKSUM = 8'h60;
    localparam logic [7:0] CMD_ACCESS_CTRL = 8'h61;
    localparam int BLOCK_BYTES = 32;
    localparam logic [5:0] BLOCK_BYTES_W = 6'h20;
    localparam logic [5:0] LEN_MAX = 6'h3f;
    // ------------------------------------------------------------------
    // Selection codes and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] GENERAL_ACCESS = 8'h00;
    localparam logic [7:0] INFO_A = 8'h01;
    localparam logic [7:0] INFO_C = 8'h03;
    localparam logic [7:0] MFR_SUBCLASS = 8'h3a;
    localparam logic [7:0] KEY_SUBCLASS = 8'h70;
    localparam logic [7:0] KEY_BLOCK = 8'h00;
    localparam logic [7:0] ACCESS_CTRL_RESET = 8'h00;
    localparam logic [7:0] SELECT_RESET = 8'h00;
    localparam logic [15:0] CTRL_SEAL_CMD = 16'h0020;
    // Default keys are arbitrary values
    localparam logic [63:0] KEY_RESET = 64'h4444_3333_2222_1111;
    // ------------------------------------------------------------------
    // Parameter memory geometry
    // ------------------------------------------------------------------
    localparam int NV_ROWS = 67;
    localparam logic [6:0] NV_GEN_BASE = 7'h03;
    localparam logic [6:0] NV_KEY_ROW =
        7'(NV_GEN_BASE + {KEY_SUBCLASS[3:0], KEY_BLOCK[1:0]});
    // ------------------------------------------------------------------
    // Control status word
    // ------------------------------------------------------------------
    localparam int STAT_SEALED_BIT = 5;
    localparam int STAT_FULL_BIT = 6;
    localparam logic [15:0] STATUS_RESET = 16'h0060;
    typedef enum logic [2:0] {
        SEC_SEALED = 3'b001,
        SEC_UNSEALED = 3'b010,
        SEC_FULL = 3'b100
    } fba_sec_type;
    typedef enum logic [2:0] {
        KS_IDLE = 3'b001,
        KS_UNSEAL = 3'b010,
        KS_FULL = 3'b100
    } fba_keyseq_type;
endpackage

// ---- verification/fba_block_access_bench.sv ----
// Self-checking bench for the block window and security levels.
// Assumes the host model drives the command space.
`timescale 1ns/1ps
module fba_block_access_bench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    // Nets driven only by the instances' output ports
    wire [7:0] addr, wr_data, rd_data;
    wire wr_start, wr_en, rd_en, rd_valid, commit;
    wire [15:0] status;
    logic [7:0] d;
    logic c, v;
    int miscompares = 0;
    int checked = 0;
    always #12.5 core_clk = ~core_clk;
    fba_block_access u_dut (.i_core_clk(core_clk), .i_rst(rst),
        .i_addr(addr), .i_wr_start(wr_start), .i_wr_en(wr_en),
        .i_wr_data(wr_data), .i_rd_en(rd_en), .o_rd_data(rd_data),
        .o_rd_valid(rd_valid), .o_control_status(status),
        .o_commit(commit));
    fba_host_model u_host (.i_core_clk(core_clk), .o_addr(addr),
        .o_wr_start(wr_start), .o_wr_en(wr_en), .o_wr_data(wr_data),
        .o_rd_en(rd_en), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
        .i_commit(commit));
    // ------------------------------------------------------------------
    // Checks and report
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        u_host.rd(a, d, v);
        chk(d, e);
        chk({7'h00, v}, 8'h01);
    endtask
    task automatic stat(input logic [15:0] e);
        rdx(fba_pkg::CMD_CTRL_LO, e[7:0]);
        rdx(fba_pkg::CMD_CTRL_HI, e[15:8]);
        chk(status[7:0], e[7:0]);
        chk(status[15:8], e[15:8]);
    endtask
    task automatic ckw(input logic [7:0] a, input logic [7:0] x,
                       input logic e);
        u_host.wr(a, x, 1'b1, c);
        chk({7'h00, c}, {7'h00, e});
    endtask
    task automatic results();
        $display("comparisons %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge core_clk);
        #1;
        rst = 1'b0;
        stat(16'h0060);
        u_host.wr(fba_pkg::CMD_CLASS, 8'h02, 1'b1, c);
        rdx(fba_pkg::CMD_CLASS, 8'h00);
        u_host.key(16'h1111);
        u_host.key(16'h5555);
        u_host.key(16'h2222);
        stat(16'h0060);
        u_host.key(16'h1111);
        u_host.key(16'h2222);
        stat(16'h0040);
        u_host.key(16'h3333);
        u_host.key(16'h4444);
        stat(16'h0000);
        u_host.key(16'h1111);
        u_host.key(16'h2222);
        stat(16'h0000);
        u_host.wr(fba_pkg::CMD_ACCESS_CTRL, 8'h00, 1'b1, c);
        u_host.sel(8'h02, 8'h01);
        u_host.wblock(32, 8'h10);
        ckw(fba_pkg::CMD_CHECKSUM, 8'(u_host.sum + 8'h01), 1'b0);
        ckw(fba_pkg::CMD_CHECKSUM, u_host.sum, 1'b1);
        u_host.sel(8'h02, 8'h01);
        rdx(8'h45, 8'h15);
        rdx(8'h5f, 8'h2f);
        u_host.wblock(33, 8'h80);
        ckw(fba_pkg::CMD_CHECKSUM, u_host.sum, 1'b0);
        u_host.sel(8'h02, 8'h01);
        rdx(8'h40, 8'h10);
        u_host.sel(fba_pkg::MFR_SUBCLASS, 8'h00);
        u_host.wblock(32, 8'ha0);
        ckw(fba_pkg::CMD_CHECKSUM, u_host.sum, 1'b1);
        u_host.sel(fba_pkg::KEY_SUBCLASS, fba_pkg::KEY_BLOCK);
        rdx(8'h40, 8'h11);
        u_host.wblock(32, 8'h60);
        ckw(fba_pkg::CMD_CHECKSUM, u_host.sum, 1'b1);
        u_host.key(16'h2000);
        stat(16'h0060);
        u_host.sel(8'h00, 8'h01);
        rdx(8'h41, 8'ha1);
        u_host.wblock(32, 8'h30);
        ckw(fba_pkg::CMD_CHECKSUM, u_host.sum, 1'b0);
        rdx(8'h41, 8'ha1);
        u_host.sel(8'h00, 8'h02);
        u_host.wblock(32, 8'h55);
        ckw(fba_pkg::CMD_CHECKSUM, u_host.sum, 1'b1);
        // Old keys no longer unseal; new ones must be sent swapped
        u_host.key(16'h1111);
        u_host.key(16'h2222);
        stat(16'h0060);
        u_host.key(16'h6061);
        u_host.key(16'h6263);
        stat(16'h0040);
        u_host.sel(fba_pkg::KEY_SUBCLASS, fba_pkg::KEY_BLOCK);
        rdx(8'h40, 8'h60);
        u_host.wblock(32, 8'h60);
        ckw(fba_pkg::CMD_CHECKSUM, u_host.sum, 1'b0);
        u_host.wr(fba_pkg::CMD_ACCESS_CTRL, 8'h01, 1'b1, c);
        u_host.sel(8'h00, 8'h02);
        rdx(8'h43, 8'h58);
        u_host.sel(8'h00, 8'h00);
        rdx(8'h43, 8'h00);
        results();
    end
    // Watchdog: a hang counts as a mismatch
    initial
    begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        results();
    end
endmodule // fba_block_access_bench

// ---- verification/fba_host_model.sv ----
// Host model: byte-wide command space master for the block access path.
// Assumes its tasks are called 1 ns after a rising clock edge.
`timescale 1ns/1ps
module fba_host_model (
    input wire logic i_core_clk,
    output logic [7:0] o_addr,
    output logic o_wr_start,
    output logic o_wr_en,
    output logic [7:0] o_wr_data,
    output logic o_rd_en,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_valid,
    input wire logic i_commit
);
    logic [7:0] sum;
    initial
    begin
        o_addr = 8'h00;
        o_wr_start = 1'b0;
        o_wr_en = 1'b0;
        o_wr_data = 8'h00;
        o_rd_en = 1'b0;
        sum = 8'h00;
    end
    // ------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------
    // Commit pulse is sampled 1 ns after the edge that takes the strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic s, output logic c);
        o_addr = a;
        o_wr_data = d;
        o_wr_start = s;
        o_wr_en = 1'b1;
        @(posedge i_core_clk);
        #1;
        o_wr_en = 1'b0;
        o_wr_start = 1'b0;
        // Released data never keeps the last value
        o_wr_data = ~d;
        c = i_commit;
        @(posedge i_core_clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
        o_addr = a;
        o_rd_en = 1'b1;
        @(posedge i_core_clk);
        #1;
        o_rd_en = 1'b0;
        d = i_rd_data;
        v = i_rd_valid;
        @(posedge i_core_clk);
        #1;
    endtask
    // ------------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------------
    // Class first, then block; the spare cycle covers the window reload
    task automatic sel(input logic [7:0] cls, input logic [7:0] blk);
        logic c;
        wr(fba_pkg::CMD_CLASS, cls, 1'b1, c);
        wr(fba_pkg::CMD_BLOCK, blk, 1'b1, c);
        @(posedge i_core_clk);
        #1;
    endtask
    // Stored word is sent swapped; callers pick non-subcommand values except 16'h2000, the swapped seal subcommand
    task automatic key(input logic [15:0] stored);
        logic c;
        wr(fba_pkg::CMD_CTRL_LO, stored[15:8], 1'b1, c);
        wr(fba_pkg::CMD_CTRL_HI, stored[7:0], 1'b1, c);
    endtask
    // One transaction; offsets wrap so byte 32 lands in the window again
    task automatic wblock(input int n, input logic [7:0] seed);
        logic c;
        sum = 8'h00;
        for (int i = 0; i < n; i++)
        begin
            wr(8'(fba_pkg::CMD_WIN_BASE + (i % 32)), 8'(seed + i), i == 0, c);
            if (i < 32)
                sum = 8'(sum + seed + i);
        end
        sum = ~sum;
    endtask
endmodule // fba_host_model
